// File: ffst_pkg.sv
package ffst_pkg;
  localparam int FRAME_W = 16;
  localparam int SLICE_W = 16;
  localparam int TIME_W = 16;
  localparam bit METHOD_RESET = 1'b0;
  localparam bit METHOD_CAPTURE = 1'b1;
  // Serial command line: start bit, opcode, then frame number for a load
  localparam int OP_W = 2;
  localparam logic [1:0] OP_LOAD = 2'h1;
  localparam logic [1:0] OP_FRAME = 2'h2;
  localparam logic [1:0] OP_SLICE = 2'h3;
  localparam int SYNC_ZEROS = FRAME_W + 1;
  localparam int RX_CNT_W = $clog2(FRAME_W + 2);
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_IDLE = 2'b01,
    RX_OP = 2'b10,
    RX_DATA = 2'b11
  } ffst_rx_e;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int I2C_WAIT_NS = 1000;
  localparam int I2C_WAIT_CYC = (I2C_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int I2C_CNT_W = 8;
  // Register map, word addresses
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_NUMS = 3'h2;
  localparam logic [2:0] REG_CAPT = 3'h3;
  localparam logic [2:0] REG_PEND = 3'h4;
  localparam int CTRL_HIT_EN = 0;
  localparam int CTRL_FLUSH = 1;
  localparam int CTRL_DROP_CLR = 2;
  localparam logic CTRL_HIT_EN_RST = 1'b1;
  localparam int ST_ACTIVE = 0;
  localparam int ST_PEND = 1;
  localparam int ST_LINE_RST = 2;
  localparam int ST_I2C_RDY = 3;
  localparam int ST_TX_VALID = 4;
  localparam int ST_METHOD = 5;
  localparam int ST_DROP = 6;
  localparam int SYNC_N = 4;
endpackage

// File: ffst_cmd_rx.sv
`timescale 1ns/100ps
module ffst_cmd_rx #(
  parameter int FRAME_W = ffst_pkg::FRAME_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Sampled link bits
  input wire logic bit_stb,
  input wire logic bit_in,
  input wire logic abort,
  // Decoded commands
  output logic load_stb,
  output logic [FRAME_W-1:0] load_num,
  output logic frame_stb,
  output logic slice_stb
);
  import ffst_pkg::*;
  ffst_rx_e state_r;
  logic [RX_CNT_W-1:0] cnt_r;
  logic [RX_CNT_W-1:0] zrun_r;
  logic [1:0] op_r;
  logic [1:0] op_full;
  logic [FRAME_W-1:0] num_r;
  logic load_r;
  logic frame_r;
  logic slice_r;

  assign op_full = {op_r[0], bit_in};
  assign load_stb = load_r;
  assign load_num = num_r;
  assign frame_stb = frame_r;
  assign slice_stb = slice_r;

  // Zero run; a run longer than a command's frame number field proves the line is between commands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      zrun_r <= '0;
    end else if (bit_stb) begin
      if (bit_in) begin
        zrun_r <= '0;
      end else if (zrun_r != RX_CNT_W'(SYNC_ZEROS)) begin
        zrun_r <= zrun_r + 1'b1;
      end
    end
  end

  // Command framing; abort drops a partial command, hunting resyncs cleanly
  always_ff @(posedge clk) begin
    load_r <= 1'b0;
    frame_r <= 1'b0;
    slice_r <= 1'b0;
    if (sys_rst || abort) begin
      state_r <= RX_HUNT;
      cnt_r <= '0;
      op_r <= '0;
      if (sys_rst) begin
        num_r <= '0;
      end
    end else if (bit_stb) begin
      case (state_r)
        RX_HUNT: begin
          if (bit_in && zrun_r == RX_CNT_W'(SYNC_ZEROS)) begin
            state_r <= RX_OP;
            cnt_r <= '0;
          end
        end
        RX_IDLE: begin
          if (bit_in) begin
            state_r <= RX_OP;
            cnt_r <= '0;
          end
        end
        RX_OP: begin
          op_r <= op_full;
          if (cnt_r == RX_CNT_W'(OP_W - 1)) begin
            cnt_r <= '0;
            state_r <= (op_full == OP_LOAD) ? RX_DATA : RX_IDLE;
            frame_r <= (op_full == OP_FRAME);
            slice_r <= (op_full == OP_SLICE);
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        RX_DATA: begin
          num_r <= {num_r[FRAME_W-2:0], bit_in};
          if (cnt_r == RX_CNT_W'(FRAME_W - 1)) begin
            load_r <= 1'b1;
            state_r <= RX_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: state_r <= RX_HUNT;
      endcase
    end
  end

  rx_abort_a: assert property (@(posedge clk) disable iff (sys_rst)
    abort |=> state_r == RX_HUNT && !load_stb)
    else $error("partial command survived abort");
endmodule

// File: ffst_hit_out.sv
`timescale 1ns/100ps
module ffst_hit_out #(
  parameter int FRAME_W = ffst_pkg::FRAME_W,
  parameter int SLICE_W = ffst_pkg::SLICE_W,
  parameter int TIME_W = ffst_pkg::TIME_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic discard,
  input wire logic stop_tx,
  // Hit capture
  input wire logic hit_stb,
  input wire logic [TIME_W-1:0] hit_time,
  input wire logic [FRAME_W-1:0] hit_frame,
  input wire logic [SLICE_W-1:0] hit_slice,
  output logic hit_drop,
  // Upstream stream
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [TIME_W-1:0] tx_time,
  output logic [FRAME_W-1:0] tx_frame,
  output logic [SLICE_W-1:0] tx_slice
);
  import ffst_pkg::*;
  logic full_r;
  logic take;
  logic accept;

  // Single slot; a hit finding it occupied is lost and reported, unless the held hit leaves that cycle or discard is set
  assign tx_valid = full_r && !stop_tx;
  assign take = tx_valid && tx_ready;
  assign accept = hit_stb && (!full_r || take) && !discard;
  assign hit_drop = hit_stb && full_r && !take && !discard;

  // Slot occupancy; discard empties it without sending
  always_ff @(posedge clk) begin
    if (sys_rst || discard) begin
      full_r <= 1'b0;
    end else if (accept) begin
      full_r <= 1'b1;
    end else if (take) begin
      full_r <= 1'b0;
    end
  end

  // Three values per hit travel together
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_time <= '0;
      tx_frame <= '0;
      tx_slice <= '0;
    end else if (accept) begin
      tx_time <= hit_time;
      tx_frame <= hit_frame;
      tx_slice <= hit_slice;
    end
  end

  discard_a: assert property (@(posedge clk) disable iff (sys_rst)
    discard |=> !tx_valid)
    else $error("held hit not discarded");
endmodule

// File: ffst_frontend.sv
`timescale 1ns/100ps
module ffst_frontend #(
  parameter int FRAME_W = ffst_pkg::FRAME_W,
  parameter int SLICE_W = ffst_pkg::SLICE_W,
  parameter int TIME_W = ffst_pkg::TIME_W,
  parameter bit METHOD = ffst_pkg::METHOD_RESET
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Concentrator link
  input wire logic gclk_in,
  input wire logic cmd_in,
  input wire logic line_rst_in,
  // Detector side
  input wire logic hit_in,
  output logic digitize_en,
  output logic i2c_ready,
  // Upstream data
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [TIME_W-1:0] tx_time,
  output logic [FRAME_W-1:0] tx_frame,
  output logic [SLICE_W-1:0] tx_slice,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import ffst_pkg::*;
  logic [SYNC_N-1:0] pin_raw;
  logic [SYNC_N-1:0] sync1_r;
  logic [SYNC_N-1:0] sync2_r;
  logic gclk_d_r;
  logic hit_d_r;
  logic rst_d_r;
  logic gclk_rise;
  logic rst_s;
  logic hit_ev;
  logic rx_load;
  logic rx_frame;
  logic rx_slice;
  logic [FRAME_W-1:0] rx_num;
  logic go_load;
  logic go_frame;
  logic go_slice;
  logic new_frame;
  logic slice_adv;
  logic active_r;
  logic pend_valid_r;
  logic [FRAME_W-1:0] pend_num_r;
  logic [FRAME_W-1:0] frame_num_r;
  logic [SLICE_W-1:0] slice_num_r;
  logic [TIME_W-1:0] tcount_r;
  logic [TIME_W-1:0] cap_r;
  logic [I2C_CNT_W-1:0] i2c_cnt_r;
  logic i2c_ready_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_word;
  logic wr_ctrl;
  logic hit_en_r;
  logic flush_r;
  logic drop_r;
  logic hit_drop;
  logic [TIME_W:0] seg_cnt_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Two-stage synchronisers for every pin from the concentrator or detector
  assign pin_raw = {hit_in, line_rst_in, cmd_in, gclk_in};
  generate
    for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          sync1_r[i] <= 1'b0;
          sync2_r[i] <= 1'b0;
        end else begin
          sync1_r[i] <= pin_raw[i];
          sync2_r[i] <= sync1_r[i];
        end
      end
    end
  endgenerate

  // Edge history on the synchronised side only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gclk_d_r <= 1'b0;
      hit_d_r <= 1'b0;
      rst_d_r <= 1'b0;
    end else begin
      gclk_d_r <= sync2_r[0];
      hit_d_r <= sync2_r[3];
      rst_d_r <= sync2_r[2];
    end
  end

  // Command bit is stable at the global clock rising edge
  assign gclk_rise = sync2_r[0] && !gclk_d_r;
  assign rst_s = sync2_r[2];

  ffst_cmd_rx #(.FRAME_W(FRAME_W)) u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .bit_stb(gclk_rise),
    .bit_in(sync2_r[1]),
    .abort(rst_s),
    .load_stb(rx_load),
    .load_num(rx_num),
    .frame_stb(rx_frame),
    .slice_stb(rx_slice)
  );

  // Commands are masked for as long as the line reset is held
  assign go_load = rx_load && !rst_s;
  assign go_frame = rx_frame && !rst_s;
  assign go_slice = rx_slice && !rst_s;
  assign new_frame = go_frame && pend_valid_r;
  assign slice_adv = go_slice && active_r;

  // Frame activity status
  always_ff @(posedge clk) begin
    if (sys_rst || rst_s) begin
      active_r <= 1'b0;
    end else if (go_frame) begin
      if (pend_valid_r) begin
        active_r <= 1'b1;
      end else if (active_r) begin
        active_r <= 1'b0;
      end
    end
  end

  // Pending frame number and its valid state
  always_ff @(posedge clk) begin
    if (sys_rst || rst_s) begin
      pend_valid_r <= 1'b0;
    end else if (go_frame) begin
      pend_valid_r <= 1'b0;
    end else if (go_load) begin
      pend_valid_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_num_r <= '0;
    end else if (go_load) begin
      pend_num_r <= rx_num;
    end
  end

  // Frame and slice numbers survive a line reset so numbering stays continuous
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_num_r <= '0;
      slice_num_r <= '0;
    end else if (new_frame) begin
      frame_num_r <= pend_num_r;
      slice_num_r <= '0;
    end else if (slice_adv) begin
      slice_num_r <= slice_num_r + 1'b1;
    end
  end

  // Internal time counter runs on clk, an integer multiple of the global clock;
  // the zeroing lands a fixed number of cycles after the global clock edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tcount_r <= '0;
    end else if (METHOD == METHOD_RESET && new_frame) begin
      tcount_r <= '0;
    end else begin
      tcount_r <= tcount_r + 1'b1;
    end
  end

  // Slice start times for the capture method
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cap_r <= '0;
    end else if (METHOD == METHOD_CAPTURE && (new_frame || slice_adv)) begin
      cap_r <= tcount_r;
    end
  end

  // Hits are taken only inside an active frame and outside line reset
  assign digitize_en = active_r && hit_en_r && !rst_s;
  assign hit_ev = sync2_r[3] && !hit_d_r && digitize_en;

  ffst_hit_out #(.FRAME_W(FRAME_W), .SLICE_W(SLICE_W), .TIME_W(TIME_W)) u_out (
    .clk(clk),
    .sys_rst(sys_rst),
    .discard(rst_s || flush_r),
    .stop_tx(rst_s),
    .hit_stb(hit_ev),
    .hit_time(tcount_r),
    .hit_frame(frame_num_r),
    .hit_slice(slice_num_r),
    .hit_drop(hit_drop),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_time(tx_time),
    .tx_frame(tx_frame),
    .tx_slice(tx_slice)
  );

  // Init readiness restarts on each line reset assertion; the delay covers settling
  always_ff @(posedge clk) begin
    if (sys_rst || (rst_s && !rst_d_r)) begin
      i2c_cnt_r <= '0;
      i2c_ready_r <= 1'b0;
    end else if (i2c_cnt_r != I2C_CNT_W'(I2C_WAIT_CYC)) begin
      i2c_cnt_r <= i2c_cnt_r + 1'b1;
      i2c_ready_r <= 1'b0;
    end else begin
      i2c_ready_r <= 1'b1;
    end
  end
  assign i2c_ready = i2c_ready_r;

  // Bus handshake: one wait cycle, read data latched in it
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = rdata_r;
  assign wr_ctrl = avs_write && ack_r && avs_address == REG_CTRL && avs_byteenable[0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  // Read decode; unmapped words read zero
  always_comb begin
    rd_word = '0;
    case (avs_address)
      REG_CTRL: rd_word[CTRL_HIT_EN] = hit_en_r;
      REG_STATUS: begin
        rd_word[ST_ACTIVE] = active_r;
        rd_word[ST_PEND] = pend_valid_r;
        rd_word[ST_LINE_RST] = rst_s;
        rd_word[ST_I2C_RDY] = i2c_ready_r;
        rd_word[ST_TX_VALID] = tx_valid;
        rd_word[ST_METHOD] = METHOD;
        rd_word[ST_DROP] = drop_r;
      end
      REG_NUMS: rd_word = {frame_num_r, slice_num_r};
      REG_CAPT: rd_word = {{(32 - TIME_W){1'b0}}, cap_r};
      REG_PEND: rd_word = {{(32 - FRAME_W){1'b0}}, pend_num_r};
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else if (avs_read && !ack_r) begin
      rdata_r <= rd_word;
    end
  end

  // Control register; flush is a one-cycle discard of the held hit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hit_en_r <= CTRL_HIT_EN_RST;
      flush_r <= 1'b0;
    end else begin
      flush_r <= wr_ctrl && avs_writedata[CTRL_FLUSH];
      if (wr_ctrl) begin
        hit_en_r <= avs_writedata[CTRL_HIT_EN];
      end
    end
  end

  // Sticky lost-hit flag; a new loss beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drop_r <= 1'b0;
    end else if (hit_drop) begin
      drop_r <= 1'b1;
    end else if (wr_ctrl && avs_writedata[CTRL_DROP_CLR]) begin
      drop_r <= 1'b0;
    end
  end

  // Helper: clk cycles since the last slice boundary, saturating
  always_ff @(posedge clk) begin
    if (sys_rst || new_frame || slice_adv) begin
      seg_cnt_r <= '0;
    end else if (!seg_cnt_r[TIME_W]) begin
      seg_cnt_r <= seg_cnt_r + 1'b1;
    end
  end

  sequence frame_go_s;
    go_frame && pend_valid_r;
  endsequence
  sequence frame_end_s;
    go_frame && !pend_valid_r && active_r;
  endsequence
  sequence frame_idle_s;
    go_frame && !pend_valid_r && !active_r;
  endsequence
  sequence rst_rise_s;
    rst_s && !rst_d_r;
  endsequence

  load_pend_a: assert property (go_load |=> pend_valid_r && pend_num_r == $past(rx_num))
    else $error("load did not fill pending register");
  pend_clear_a: assert property (go_frame |=> !pend_valid_r)
    else $error("pending stayed valid after frame start");
  frame_load_a: assert property (frame_go_s |=>
    frame_num_r == $past(pend_num_r) && slice_num_r == '0)
    else $error("frame start did not load numbers");
  frame_open_a: assert property (frame_go_s ##0 !active_r |=> active_r)
    else $error("frame did not become active");
  frame_close_a: assert property (frame_end_s |=> !active_r && !digitize_en)
    else $error("frame did not close");
  frame_ignore_a: assert property (frame_idle_s |=>
    !active_r && $stable(frame_num_r) && $stable(slice_num_r))
    else $error("idle frame start not ignored");
  line_halt_a: assert property (rst_s |-> !tx_valid && !hit_ev && !digitize_en)
    else $error("activity during line reset");
  line_clear_a: assert property (rst_s |=> !active_r && !pend_valid_r)
    else $error("line reset left frame state");
  cmd_mask_a: assert property (rst_s |=>
    $stable(frame_num_r) && $stable(pend_num_r) && !pend_valid_r)
    else $error("command taken during line reset");
  slice_step_a: assert property (slice_adv |=>
    slice_num_r == SLICE_W'($past(slice_num_r) + 1'b1))
    else $error("slice number not incremented");
  time_wrap_a: assert property (tcount_r == '1 && !new_frame |=> tcount_r == '0)
    else $error("time counter did not wrap");
  time_zero_a: assert property (new_frame && METHOD == METHOD_RESET |=> tcount_r == '0)
    else $error("time counter not zeroed");
  capture_a: assert property ((new_frame || slice_adv) && METHOD == METHOD_CAPTURE
    |=> cap_r == $past(tcount_r))
    else $error("slice start time not captured");
  init_ready_a: assert property (rst_rise_s |=> !i2c_ready_r ##[100:102] i2c_ready_r)
    else $error("init readiness late");
  bus_wait_a: assert property ((avs_read || avs_write) && !ack_r |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  slice_span_a: assert property (slice_adv |-> (METHOD == METHOD_CAPTURE)
    ? !seg_cnt_r[TIME_W] : !seg_cnt_r[TIME_W] && !seg_cnt_r[TIME_W-1])
    else $error("slice longer than counter rollover allows");
endmodule

// File: ffst_link_model.sv
`timescale 1ns/100ps
module ffst_link_model (
  // Link toward the front end
  output logic gclk_in,
  output logic cmd_in,
  output logic line_rst_in
);
  import ffst_pkg::*;

  // Global clock runs free, commands ride on it
  initial begin
    gclk_in = 1'b0;
    forever #40 gclk_in = ~gclk_in;
  end

  // Line idles low, reset line released
  initial begin
    cmd_in = 1'b0;
    line_rst_in = 1'b0;
  end

  // Bits change on falling edge, stable at rising; idle zero after each
  task automatic send_bits(input logic [FRAME_W+2:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge gclk_in);
      cmd_in = bits[i];
    end
    @(negedge gclk_in);
    cmd_in = 1'b0;
  endtask

  // Whole command, never a fragment
  task automatic send_cmd(input logic [1:0] op, input logic [FRAME_W-1:0] num);
    if (op == OP_LOAD) begin
      send_bits({1'b1, op, num}, FRAME_W + 3);
    end else begin
      send_bits({{FRAME_W{1'b0}}, 1'b1, op}, 3);
    end
  endtask

  // Zero bits so the receiver can find alignment
  task automatic idle(input int n);
    repeat (n) @(negedge gclk_in);
  endtask

  // Reset line level, moved away from sampling edge
  task automatic set_line_rst(input logic v);
    @(negedge gclk_in);
    line_rst_in = v;
  endtask
endmodule

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
  import ffst_pkg::*;
  logic clk, sys_rst, gclk_in, cmd_in, line_rst_in, hit_in, digitize_en, i2c_ready;
  logic tx_ready, tx_valid, avs_read, avs_write, avs_waitrequest;
  logic [TIME_W-1:0] tx_time;
  logic [FRAME_W-1:0] tx_frame;
  logic [SLICE_W-1:0] tx_slice;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, prev;
  logic [3:0] avs_byteenable;
  int bad_count;
  int n_compared;

  ffst_frontend ffst_frontend_inst (.clk(clk), .sys_rst(sys_rst), .gclk_in(gclk_in),
    .cmd_in(cmd_in), .line_rst_in(line_rst_in), .hit_in(hit_in),
    .digitize_en(digitize_en), .i2c_ready(i2c_ready), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_time(tx_time), .tx_frame(tx_frame), .tx_slice(tx_slice),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  ffst_link_model ffst_link_model_inst (.gclk_in(gclk_in), .cmd_in(cmd_in),
    .line_rst_in(line_rst_in));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Avalon read: hold until waitrequest is sampled low, take data at that edge
  task automatic avs_rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // Avalon write: lands at the edge where waitrequest is sampled low
  task automatic avs_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_write <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    avs_write <= 1'b0;
    avs_byteenable <= 4'h0;
  endtask

  // Status bits except init-ready, which moves with its own delay
  task automatic st(input logic [31:0] exp);
    avs_rd(REG_STATUS, rd);
    chk("status", exp, rd & 32'h77);
  endtask

  task automatic nums(input logic [31:0] exp);
    avs_rd(REG_NUMS, rd);
    chk("frame and slice", exp, rd);
  endtask

  // Command plus margin for synchronisers and decode
  task automatic cmd(input logic [1:0] op, input logic [FRAME_W-1:0] num);
    ffst_link_model_inst.send_cmd(op, num);
    repeat (8) @(posedge clk);
  endtask

  // Hit held well past the synchroniser
  task automatic hit_pulse;
    @(posedge clk);
    hit_in <= 1'b1;
    repeat (4) @(posedge clk);
    hit_in <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic wait_tx;
    int n;
    n = 0;
    while (tx_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("tx_valid", 32'h1, {31'h0, tx_valid});
  endtask

  task automatic drain;
    @(posedge clk);
    tx_ready <= 1'b1;
    @(posedge clk);
    tx_ready <= 1'b0;
    @(negedge clk);
    chk("tx_valid drained", 32'h0, {31'h0, tx_valid});
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog, above the roughly 70000 cycles the tests need, wrap wait included
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    hit_in = 1'b0;
    tx_ready = 1'b0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    bad_count = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("i2c_ready early", 32'h0, {31'h0, i2c_ready});
    avs_rd(REG_CTRL, rd);
    chk("hit enable", 32'h1, rd & 32'h1);
    avs_wr(3'h6, 32'hffffffff);
    avs_rd(3'h6, rd);
    chk("unmapped", 32'h0, rd);
    st(32'h0);
    repeat (110) @(posedge clk);
    chk("i2c_ready", 32'h1, {31'h0, i2c_ready});
    $display("test reset done");
    ffst_link_model_inst.idle(20);
    cmd(OP_FRAME, 16'h0);
    st(32'h0);
    avs_rd(REG_NUMS, prev);
    cmd(OP_SLICE, 16'h0);
    nums(prev);
    cmd(OP_LOAD, 16'h1234);
    st(32'h2);
    avs_rd(REG_PEND, rd);
    chk("pending", 32'h1234, rd);
    cmd(OP_FRAME, 16'h0);
    st(32'h1);
    nums(32'h12340000);
    chk("digitize_en", 32'h1, {31'h0, digitize_en});
    repeat (3) cmd(OP_SLICE, 16'h0);
    nums(32'h12340003);
    $display("test frame start done");
    hit_pulse();
    wait_tx();
    chk("tx_frame", 32'h1234, {16'h0, tx_frame});
    chk("tx_slice", 32'h3, {16'h0, tx_slice});
    chk("tx_time since frame", 32'h1, {31'h0, tx_time < 16'h0180});
    hit_pulse();
    st(32'h51);
    avs_wr(REG_CTRL, 32'h5);
    st(32'h11);
    drain();
    hit_pulse();
    wait_tx();
    avs_wr(REG_CTRL, 32'h3);
    st(32'h1);
    // Hit enable cleared: no hit may be taken inside the frame
    avs_wr(REG_CTRL, 32'h0);
    @(negedge clk);
    chk("digitize_en masked", 32'h0, {31'h0, digitize_en});
    hit_pulse();
    st(32'h1);
    avs_wr(REG_CTRL, 32'h1);
    $display("test hits done");
    cmd(OP_LOAD, 16'h1235);
    cmd(OP_FRAME, 16'h0);
    st(32'h1);
    nums(32'h12350000);
    cmd(2'h0, 16'h0);
    st(32'h1);
    nums(32'h12350000);
    hit_pulse();
    wait_tx();
    cmd(OP_FRAME, 16'h0);
    st(32'h10);
    chk("digitize_en stop", 32'h0, {31'h0, digitize_en});
    drain();
    repeat (65600) @(posedge clk);
    $display("test frame stop done");
    cmd(OP_LOAD, 16'h2000);
    cmd(OP_FRAME, 16'h0);
    hit_pulse();
    wait_tx();
    // Line reset cuts a load in mid-command; its tail must not land
    fork
      ffst_link_model_inst.send_cmd(OP_LOAD, 16'h2001);
      begin
        repeat (96) @(posedge clk);
        ffst_link_model_inst.set_line_rst(1'b1);
      end
    join
    repeat (6) @(posedge clk);
    chk("tx_valid in reset", 32'h0, {31'h0, tx_valid});
    chk("digitize_en in reset", 32'h0, {31'h0, digitize_en});
    chk("i2c_ready in reset", 32'h0, {31'h0, i2c_ready});
    st(32'h4);
    cmd(OP_LOAD, 16'h3000);
    st(32'h4);
    avs_rd(REG_PEND, rd);
    chk("pending kept", 32'h2000, rd);
    ffst_link_model_inst.set_line_rst(1'b0);
    repeat (6) @(posedge clk);
    chk("tx_valid after reset", 32'h0, {31'h0, tx_valid});
    st(32'h0);
    ffst_link_model_inst.idle(20);
    cmd(OP_LOAD, 16'h4000);
    cmd(OP_FRAME, 16'h0);
    st(32'h1);
    nums(32'h40000000);
    chk("i2c_ready again", 32'h1, {31'h0, i2c_ready});
    $display("test line reset done");
    tally_and_finish();
  end
endmodule
